// ==== verilog/trip_pkg.sv ====
// Package with constants and carrier types for the trip and start protection block.
package trip_pkg;

   localparam int NUM_INPUTS = 5;
   localparam logic [1:0] SETTLE_CYCLES = 2'h2;
   localparam logic [4:0] FUNC_EXT_TRIP = 5'h0C;
   localparam logic [4:0] FUNC_START_INTERLOCK = 5'h0D;
   localparam logic [7:0] ERR_NONE = 8'h00;
   localparam logic [7:0] ERR_EXT_TRIP = 8'h0C;
   localparam logic [7:0] ERR_START_INTERLOCK = 8'h0D;

   typedef enum logic [1:0] {
      ST_STOP = 2'b00,
      ST_RUN = 2'b01,
      ST_EXT_TRIP = 2'b10,
      ST_USP_TRIP = 2'b11
   } drive_state_type;

   typedef struct packed {
      logic run_cmd;
      logic keypad_reset;
      logic reset_terminal;
   } command_type;

   typedef struct packed {
      logic motor_enable;
      logic alarm;
      logic [7:0] error_code;
   } status_type;

endpackage

// ==== verilog/trip_and_start_protection.sv ====
// Fault latch and power-up start interlock for a motor drive.
`timescale 1ns/10ps
`default_nettype none
module trip_and_start_protection (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst_n,
   // Terminal function assignment, one code per intelligent input.
   input wire logic [trip_pkg::NUM_INPUTS*5-1:0] input_function,
   // Intelligent input pins, asynchronous.
   input wire logic [trip_pkg::NUM_INPUTS-1:0] input_pins,
   // Operator commands, asynchronous.
   input wire trip_pkg::command_type cmd,
   // Drive status.
   output trip_pkg::status_type status
);

   logic [trip_pkg::NUM_INPUTS-1:0] pin_meta_r;
   logic [trip_pkg::NUM_INPUTS-1:0] pin_sync_r;
   logic [2:0] cmd_meta_r;
   logic [2:0] cmd_sync_r;
   logic [trip_pkg::NUM_INPUTS*5-1:0] func_meta_r;
   logic [trip_pkg::NUM_INPUTS*5-1:0] func_sync_r;

   logic ext_in_d_r;
   logic run_d_r;
   logic powerup_r;
   logic usp_block_r;
   logic reset_d_r;
   logic [1:0] settle_r;

   trip_pkg::drive_state_type state_r;
   trip_pkg::drive_state_type state_nxt;
   logic [7:0] err_r;
   logic [7:0] err_nxt;
   logic motor_enable_r;
   logic alarm_r;
   logic [7:0] error_code_r;

   logic external_fault_input;
   logic powerup_start_interlock;
   logic run_cmd;
   logic reset_any;
   logic run_rise;
   logic ext_rise;
   logic reset_rise;
   logic settled;
   logic powerup_check;
   logic [trip_pkg::NUM_INPUTS-1:0] ext_mask;
   logic [trip_pkg::NUM_INPUTS-1:0] usp_mask;

   function automatic logic [trip_pkg::NUM_INPUTS-1:0] pins_with(
      input logic [trip_pkg::NUM_INPUTS*5-1:0] funcs,
      input logic [4:0] code
   );
      logic [trip_pkg::NUM_INPUTS-1:0] hit;
      hit = '0;
      for (int i = 0; i < trip_pkg::NUM_INPUTS; i++) begin
         hit[i] = (funcs[i*5 +: 5] == code);
      end
      return hit;
   endfunction

   // A state that holds the motor off and raises the alarm.
   function automatic logic is_trip(
      input trip_pkg::drive_state_type st
   );
      return (st == trip_pkg::ST_EXT_TRIP) || (st == trip_pkg::ST_USP_TRIP);
   endfunction

   function automatic logic is_run(
      input trip_pkg::drive_state_type st
   );
      return (st == trip_pkg::ST_RUN);
   endfunction

   // Each intelligent input passes two flip-flops before any logic reads it.
   for (genvar p = 0; p < trip_pkg::NUM_INPUTS; p++) begin : g_pin_sync
      always_ff @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) begin
            pin_meta_r[p] <= 1'b0;
         end else begin
            pin_meta_r[p] <= input_pins[p];
         end
      end

      always_ff @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) begin
            pin_sync_r[p] <= 1'b0;
         end else begin
            pin_sync_r[p] <= pin_meta_r[p];
         end
      end
   end

   // The operator commands pass the same two flip-flops.
   for (genvar c = 0; c < 3; c++) begin : g_cmd_sync
      always_ff @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) begin
            cmd_meta_r[c] <= 1'b0;
         end else begin
            cmd_meta_r[c] <= cmd[c];
         end
      end

      always_ff @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) begin
            cmd_sync_r[c] <= 1'b0;
         end else begin
            cmd_sync_r[c] <= cmd_meta_r[c];
         end
      end
   end

   // The function codes come from outside the clock domain as well.
   for (genvar f = 0; f < trip_pkg::NUM_INPUTS; f++) begin : g_func_sync
      always_ff @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) begin
            func_meta_r[f*5 +: 5] <= 5'h00;
         end else begin
            func_meta_r[f*5 +: 5] <= input_function[f*5 +: 5];
         end
      end

      always_ff @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) begin
            func_sync_r[f*5 +: 5] <= 5'h00;
         end else begin
            func_sync_r[f*5 +: 5] <= func_meta_r[f*5 +: 5];
         end
      end
   end

   // Marks the inputs that carry each trip function.
   always_comb begin
      ext_mask = pins_with(func_sync_r, trip_pkg::FUNC_EXT_TRIP);
      usp_mask = pins_with(func_sync_r, trip_pkg::FUNC_START_INTERLOCK);
   end

   // Counts the synchroniser edges after reset so the power-up check sees settled levels.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         settle_r <= 2'h0;
      end else if (settle_r != trip_pkg::SETTLE_CYCLES) begin
         settle_r <= settle_r + 2'h1;
      end
   end

   assign settled = (settle_r == trip_pkg::SETTLE_CYCLES);
   assign powerup_check = powerup_r && settled;

   assign external_fault_input = |(pin_sync_r & ext_mask);
   assign powerup_start_interlock = |(pin_sync_r & usp_mask);
   assign run_cmd = cmd_sync_r[2];
   assign reset_any = cmd_sync_r[1] | cmd_sync_r[0];
   assign run_rise = run_cmd & ~run_d_r;
   assign ext_rise = external_fault_input & ~ext_in_d_r;
   assign reset_rise = reset_any & ~reset_d_r;

   // Last level of the fault input, for its off-to-on edge.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ext_in_d_r <= 1'b0;
      end else begin
         ext_in_d_r <= external_fault_input;
      end
   end

   // Last level of the run command, for a fresh run edge.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         run_d_r <= 1'b0;
      end else begin
         run_d_r <= run_cmd;
      end
   end

   // Last level of the reset commands, so a new press, not a held one, releases the interlock block.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         reset_d_r <= 1'b0;
      end else begin
         reset_d_r <= reset_any;
      end
   end

   // The first cycle after power-up, once synchronisers have settled, checks for a pending run.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         powerup_r <= 1'b1;
      end else if (settled && state_r == trip_pkg::ST_STOP) begin
         powerup_r <= 1'b0;
      end
   end

   // With the interlock, a cleared external trip waits for a fresh run edge or a new reset press before restarting.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         usp_block_r <= 1'b0;
      end else if (state_r == trip_pkg::ST_EXT_TRIP && reset_any) begin
         usp_block_r <= powerup_start_interlock;
      end else if (run_rise || reset_rise || !run_cmd) begin
         usp_block_r <= 1'b0;
      end
   end

   // Next state and error code of the trip and run sequence.
   always_comb begin
      state_nxt = state_r;
      err_nxt = err_r;
      case (state_r)
         trip_pkg::ST_STOP: begin
            if (ext_rise) begin
               state_nxt = trip_pkg::ST_EXT_TRIP;
               err_nxt = trip_pkg::ERR_EXT_TRIP;
            end else if (powerup_check && run_cmd && powerup_start_interlock) begin
               state_nxt = trip_pkg::ST_USP_TRIP;
               err_nxt = trip_pkg::ERR_START_INTERLOCK;
            end else if (run_cmd && !reset_any && !usp_block_r) begin
               state_nxt = trip_pkg::ST_RUN;
            end
         end

         trip_pkg::ST_RUN: begin
            if (ext_rise) begin
               state_nxt = trip_pkg::ST_EXT_TRIP;
               err_nxt = trip_pkg::ERR_EXT_TRIP;
            end else if (!run_cmd || reset_any) begin
               state_nxt = trip_pkg::ST_STOP;
            end
         end

         trip_pkg::ST_EXT_TRIP: begin
            if (reset_any) begin
               state_nxt = trip_pkg::ST_STOP;
               err_nxt = trip_pkg::ERR_NONE;
            end
         end

         trip_pkg::ST_USP_TRIP: begin
            if (ext_rise) begin
               state_nxt = trip_pkg::ST_EXT_TRIP;
               err_nxt = trip_pkg::ERR_EXT_TRIP;
            end else if (!run_cmd || reset_any) begin
               state_nxt = trip_pkg::ST_STOP;
               err_nxt = trip_pkg::ERR_NONE;
            end
         end

         default: begin
            state_nxt = trip_pkg::ST_STOP;
            err_nxt = trip_pkg::ERR_NONE;
         end
      endcase
   end

   // State of the trip and run sequence.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= trip_pkg::ST_STOP;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Recorded error code.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         err_r <= trip_pkg::ERR_NONE;
      end else begin
         err_r <= err_nxt;
      end
   end

   // Outputs are registered from the next state so the trip shows on the edge that detects it.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         motor_enable_r <= 1'b0;
      end else begin
         motor_enable_r <= is_run(state_nxt);
      end
   end

   // The alarm rises on the edge that latches either trip.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         alarm_r <= 1'b0;
      end else begin
         alarm_r <= is_trip(state_nxt);
      end
   end

   // The error code shown beside the alarm.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         error_code_r <= trip_pkg::ERR_NONE;
      end else begin
         error_code_r <= err_nxt;
      end
   end

   assign status = '{motor_enable: motor_enable_r, alarm: alarm_r, error_code: error_code_r};

endmodule
`default_nettype wire

// ==== test/trip_sva.sv ====
// Checker for the trip and start protection block.
`timescale 1ns/10ps
`default_nettype none
module trip_sva (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [trip_pkg::NUM_INPUTS*5-1:0] input_function,
   input wire logic [trip_pkg::NUM_INPUTS-1:0] input_pins,
   input wire trip_pkg::command_type cmd,
   input wire trip_pkg::status_type status
);
   logic ext_lvl;
   logic usp_lvl;
   logic rstc;
   logic [2:0] quiet_r;
   assign rstc = cmd.keypad_reset | cmd.reset_terminal;
   always_comb begin
      ext_lvl = 1'b0;
      usp_lvl = 1'b0;
      for (int i = 0; i < trip_pkg::NUM_INPUTS; i++) begin
         ext_lvl |= input_pins[i] && input_function[i*5+:5] == trip_pkg::FUNC_EXT_TRIP;
         usp_lvl |= input_pins[i] && input_function[i*5+:5] == trip_pkg::FUNC_START_INTERLOCK;
      end
   end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         quiet_r <= 3'h0;
      end else if (rstc) begin
         quiet_r <= 3'h0;
      end else if (quiet_r != 3'h7) begin
         quiet_r <= quiet_r + 3'h1;
      end
   end
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   a_ext_trip_code: assert property ($rose(ext_lvl) && !rstc |-> ##[1:4]
      (status.alarm && status.error_code == trip_pkg::ERR_EXT_TRIP)) else $error("no ext trip");
   a_trip_holds: assert property ($past(status.error_code) == trip_pkg::ERR_EXT_TRIP
      && quiet_r > 3'h3 |-> status.error_code == trip_pkg::ERR_EXT_TRIP) else $error("trip lost");
   a_reset_clears: assert property (rstc [*4] |-> !status.alarm
      && status.error_code == trip_pkg::ERR_NONE) else $error("reset did not clear");
   a_reset_stops: assert property (rstc [*4] |-> !status.motor_enable)
      else $error("motor on in reset");
   a_trip_no_drive: assert property (status.alarm |-> !status.motor_enable)
      else $error("motor on in trip");
   a_code_alarm: assert property (status.alarm == (status.error_code != 8'h00))
      else $error("alarm and code disagree");
   a_motor_cause: assert property (status.motor_enable |->
      $past(cmd.run_cmd, 3) || $past(cmd.run_cmd, 4)) else $error("motor without run");
   a_resume_run: assert property ((cmd.run_cmd && !rstc && !usp_lvl
      && status.error_code == trip_pkg::ERR_NONE) [*6] |-> status.motor_enable)
      else $error("run not resumed");
   cover property ($rose(status.alarm));
   cover property (status.error_code == trip_pkg::ERR_START_INTERLOCK);
   cover property ($rose(status.motor_enable));
endmodule
bind trip_and_start_protection trip_sva chk_u (.ref_clk(ref_clk), .rst_n(rst_n),
   .input_function(input_function), .input_pins(input_pins), .cmd(cmd), .status(status));
`default_nettype wire

// ==== test/field_equipment.sv ====
// Operator switches and field equipment that drive the block's inputs.
`timescale 1ns/10ps
`default_nettype none
module field_equipment (
   // Requested levels: run, keypad reset, reset terminal, interlock, fault.
   input wire logic [4:0] want,
   // Levels at the block's inputs.
   output var logic [trip_pkg::NUM_INPUTS-1:0] input_pins,
   output var trip_pkg::command_type cmd
);
   always_comb begin
      input_pins = {3'h0, want[1:0]};
      cmd = want[4:2];
   end
endmodule
`default_nettype wire

// ==== test/trip_and_start_protection_tb.sv ====
// Self-checking bench for the trip and start protection block.
`timescale 1ns/10ps
`default_nettype none
module trip_and_start_protection_tb;
   typedef struct packed {logic [4:0] want; logic [9:0] exp;} row_type;
   localparam row_type ROWS [8] = '{{5'h11, 10'h10C}, {5'h10, 10'h10C}, {5'h14, 10'h000},
      {5'h10, 10'h200}, {5'h11, 10'h10C}, {5'h19, 10'h000}, {5'h10, 10'h200}, {5'h00, 10'h000}};
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [4:0] want = 5'h10;
   logic [24:0] funcs = {15'h0000, trip_pkg::FUNC_START_INTERLOCK, trip_pkg::FUNC_EXT_TRIP};
   logic [4:0] pins;
   trip_pkg::command_type cmd;
   trip_pkg::status_type status;
   int num_errors = 0;
   int check_count = 0;
   field_equipment model_u (.want(want), .input_pins(pins), .cmd(cmd));
   trip_and_start_protection dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .input_function(funcs),
      .input_pins(pins), .cmd(cmd), .status(status));
   always #12.5 ref_clk = ~ref_clk;
   task automatic check(input string what, input logic [9:0] exp);
      @(negedge ref_clk);
      check_count++;
      if (status !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, status);
      end
      @(posedge ref_clk);
   endtask
   task automatic apply(input logic [4:0] w);
      want <= w;
      repeat (8) @(posedge ref_clk);
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge ref_clk);
      check("reset status", 10'h000);
      rst_n <= 1'b1;
      apply(5'h10);
      check("powerup run", 10'h200);
      foreach (ROWS[i]) begin
         apply(ROWS[i].want);
         check("row status", ROWS[i].exp);
      end
      rst_n <= 1'b0;
      want <= 5'h12;
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      apply(5'h12);
      check("powerup interlock", 10'h10D);
      apply(5'h02);
      check("interlock cleared", 10'h000);
      apply(5'h12);
      check("new run", 10'h200);
      apply(5'h13);
      apply(5'h16);
      apply(5'h12);
      check("no auto restart", 10'h000);
      apply(5'h02);
      apply(5'h12);
      check("fresh run edge", 10'h200);
      end_of_test();
   end
endmodule
`default_nettype wire
